// File: include/plpc_params.svh
// Offsets, fields, reset values and timing counts of the link and pause control block
`ifndef PLPC_PARAMS_SVH
`define PLPC_PARAMS_SVH
// ====================================================================
// Register byte addresses
`define PLPC_ADDR_BUS_MODE 8'h00
`define PLPC_ADDR_PHY_CTRL 8'h04
`define PLPC_ADDR_PHY_CFG 8'h08
`define PLPC_ADDR_AN_ADV 8'h0C
`define PLPC_ADDR_AN_RES 8'h10
// ====================================================================
// Field positions
`define PLPC_BM_SOFT_RST 0
`define PLPC_CTRL_PHY_RST 15
`define PLPC_CTRL_INT_LB 14
`define PLPC_CTRL_SPEED100 13
`define PLPC_CTRL_AN_EN 12
`define PLPC_CTRL_FULL 8
`define PLPC_CFG_RMT_LB 9
`define PLPC_CFG_NRZI_EN 7
`define PLPC_CFG_LED4 0
`define PLPC_ADV_PAUSE 10
`define PLPC_ADV_100FD 8
`define PLPC_ADV_100HD 7
`define PLPC_ADV_10FD 6
`define PLPC_ADV_10HD 5
// ====================================================================
// Reset values
`define PLPC_CTRL_RST 16'h3100
`define PLPC_CFG_RST 16'h0080
`define PLPC_ADV_RST 16'h05E1
// ====================================================================
// Pause frame recognition
`define PLPC_MAC_CTL_TYPE 16'h8808
`define PLPC_PAUSE_OPCODE 16'h0001
`define PLPC_PAUSE_MCAST 48'h0180C2000001
// ====================================================================
// Timing
`define PLPC_CLK_NS 40
`define PLPC_SLOT_NS_100 5120
`define PLPC_SLOT_NS_10 51200
`define PLPC_SLOT_CYC_100 (`PLPC_SLOT_NS_100 / `PLPC_CLK_NS)
`define PLPC_SLOT_CYC_10 (`PLPC_SLOT_NS_10 / `PLPC_CLK_NS)
`define PLPC_BLINK20_HALF_NS 25000000
`define PLPC_BLINK20_HALF_CYC (`PLPC_BLINK20_HALF_NS / `PLPC_CLK_NS)
`define PLPC_RST_HOLD_MS 100
`endif

// File: include/plpc_pkg.sv
// Types shared by the link and pause control block
package plpc_pkg;
	typedef logic [15:0] plpc_word_t;
	typedef enum logic [1:0]
	{
		PLPC_AN_IDLE = 2'b00,
		PLPC_AN_SEND = 2'b01,
		PLPC_AN_DONE = 2'b10
	} plpc_an_e;
endpackage

// File: include/plpc_link_if.sv
// Signals between the top, the carrier detector and the pause timer
`timescale 1ns/1ps
`default_nettype none
interface plpc_link_if;
	logic bit_tick;
	logic rx_nrz;
	logic end_det;
	logic crs_rx;
	logic slot_tick;
	logic load;
	logic [15:0] load_val;
	logic pause_en;
	logic paused;
	modport crs_top (output bit_tick, rx_nrz, end_det, input crs_rx);
	modport crs (input bit_tick, rx_nrz, end_det, output crs_rx);
	modport pse_top (output slot_tick, load, load_val, pause_en, input paused);
	modport pse (input slot_tick, load, load_val, pause_en, output paused);
endinterface
`default_nettype wire

// File: logic/plpc_crs_det.sv
// Receive carrier detector over a ten bit window
`timescale 1ns/1ps
`default_nettype none
module plpc_crs_det
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Link group
	plpc_link_if.crs lnk
);
	logic [9:0] win_q;
	logic [9:0] win_d;
	logic hit;

	function automatic logic two_zeros_apart(input logic [9:0] w);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			for (int j = i + 2; j < 10; j++)
			begin
				r = r | (!w[i] & !w[j]);
			end
		end
		return r;
	endfunction

	assign win_d = {win_q[8:0], lnk.rx_nrz};
	assign hit = lnk.bit_tick & two_zeros_apart(win_d);

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			win_q <= 10'h3FF;
		else if (lnk.bit_tick)
			win_q <= win_d;
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			lnk.crs_rx <= 1'b0;
		else if (hit)
			lnk.crs_rx <= 1'b1;
		else if (lnk.end_det)
			lnk.crs_rx <= 1'b0;
	end

	a_crs_set_win: assert property (@(posedge clk_i) disable iff (!rst_b_i) hit |=> lnk.crs_rx)
		else $error("carrier not raised after two separated zeros");
	a_crs_end_clr: assert property (@(posedge clk_i) disable iff (!rst_b_i) lnk.end_det && !hit |=> !lnk.crs_rx)
		else $error("carrier not dropped on end of stream");
endmodule
`default_nettype wire

// File: logic/plpc_pause_timer.sv
// Pause timer counting slot times
`timescale 1ns/1ps
`default_nettype none
module plpc_pause_timer
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Pause group
	plpc_link_if.pse lnk
);
	logic [15:0] cnt_q;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			cnt_q <= 16'h0000;
		else if (!lnk.pause_en)
			cnt_q <= 16'h0000;
		else if (lnk.load)
			cnt_q <= lnk.load_val;
		else if (lnk.slot_tick && cnt_q != 16'h0000)
			cnt_q <= cnt_q - 16'h0001;
	end

	assign lnk.paused = (cnt_q != 16'h0000);

	a_zero_exit_now: assert property (@(posedge clk_i) disable iff (!rst_b_i) lnk.pause_en && lnk.load && lnk.load_val == 16'h0000 |=> !lnk.paused)
		else $error("zero pause time did not leave pause");
	a_load_pause_val: assert property (@(posedge clk_i) disable iff (!rst_b_i) lnk.pause_en && lnk.load |=> cnt_q == $past(lnk.load_val))
		else $error("pause timer not loaded");
	a_slot_count_down: assert property (@(posedge clk_i) disable iff (!rst_b_i) lnk.pause_en && !lnk.load && lnk.slot_tick && cnt_q > 16'h0001 |=> cnt_q == $past(cnt_q) - 16'h0001)
		else $error("pause timer missed a slot");
	c_pause_ended: cover property (@(posedge clk_i) disable iff (!rst_b_i) lnk.paused ##1 !lnk.paused);
endmodule
`default_nettype wire

// File: logic/plpc_top.sv
// Link side control: carrier, collision, loop-back, auto-negotiation, pause, LEDs, resets
`timescale 1ns/1ps
`default_nettype none
`include "plpc_params.svh"
// How it works
// - Two separated zeros in ten bits raise carrier
// - Half duplex carrier includes transmit
// - Collision only in half duplex overlap
// - NRZI enable clear bypasses receive decode
// - Internal loop-back isolates line pins
// - Remote loop-back only at 100 Mb/s
// - 100 internal loop-back uses NRZI stream
// - Remote loop-back returns recovered data out
// - 10 loop-back feeds Manchester into recovery
// - Autoneg enable bit; otherwise programmed mode
// - Advertise sixteen bits, pick highest common
// - Negotiation starts only while enabled
// - Pause only after full duplex pause result
// - Valid pause frame loads the timer
// - Hold new frames, never cut ongoing
// - Zero pause time leaves pause at once
// - Three LED mode indications
// - Four LED mode indications
// - Soft reset spares transceiver, self-clears
// - Transceiver reset restores defaults, self-clears
module plpc_top
	import plpc_pkg::*;
#(
	parameter int LED_TICK_CYC = `PLPC_BLINK20_HALF_CYC
)
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// APB slave
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Line pins in the link clock domain
	input wire logic rx_bclk_i,
	input wire logic rx_cdr_bit_i,
	input wire logic rx_line10_i,
	// Transmit path
	input wire logic tx_nrz_bit_i,
	input wire logic tx_manch_i,
	input wire logic tx_active_i,
	// Receive decoder and link monitor
	input wire logic rx_esd_i,
	input wire logic rx_idle_i,
	input wire logic link_ok_i,
	input wire plpc_pkg::plpc_word_t lp_ability_i,
	input wire logic lp_page_valid_i,
	// Received frame fields
	input wire logic rx_frame_done_i,
	input wire logic [47:0] rx_da_i,
	input wire logic [15:0] rx_type_i,
	input wire logic [15:0] rx_opcode_i,
	input wire logic [15:0] rx_param_i,
	input wire logic [47:0] station_addr_i,
	// Line and status outputs
	output logic line_tx_bit_o,
	output logic line_drv_en_o,
	output logic cdr10_in_o,
	output logic crs_o,
	output logic col_o,
	output logic flp_send_o,
	output plpc_pkg::plpc_word_t advert_word_o,
	output logic tx_start_ok_o,
	output logic paused_o,
	output logic [3:0] led_o
);
	import plpc_pkg::*;

	plpc_link_if lnk ();

	logic [1:0] rst_sync_q;
	logic rst_b;
	logic [2:0] bclk_q;
	logic [1:0] cdr_q;
	logic [1:0] l10_q;
	logic bit_tick;
	logic rx_cdr_s;
	logic bus_mode_q;
	logic [15:0] ctrl_q;
	logic [15:0] cfg_q;
	logic [15:0] adv_q;
	logic pready_q;
	logic wr_en;
	logic phy_rst;
	plpc_an_e an_q;
	logic res_100_q;
	logic res_full_q;
	logic res_pause_q;
	logic speed100;
	logic full;
	logic int_lb;
	logic rmt_lb;
	logic tx_nrzi_q;
	logic rx_prev_q;
	logic rx_in;
	logic [10:0] slot_cnt_q;
	logic slot_end;
	logic [19:0] led_cnt_q;
	logic blink20_q;
	logic blink10_q;
	logic mac_rst;
	logic pause_frame;

	// ====================================================================
	// Reset and pin synchronisers
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_b = rst_sync_q[1];

	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bclk_q <= 3'b000;
			cdr_q <= 2'b00;
			l10_q <= 2'b00;
		end
		else
		begin
			bclk_q <= {bclk_q[1:0], rx_bclk_i};
			cdr_q <= {cdr_q[0], rx_cdr_bit_i};
			l10_q <= {l10_q[0], rx_line10_i};
		end
	end
	// Edge found from the second and third stages only
	assign bit_tick = bclk_q[1] & !bclk_q[2];
	assign rx_cdr_s = cdr_q[1];

	// ====================================================================
	// APB slave, one wait state, unmapped addresses answer with an error
	function automatic logic addr_hit(input logic [7:0] a);
		return a == `PLPC_ADDR_BUS_MODE || a == `PLPC_ADDR_PHY_CTRL || a == `PLPC_ADDR_PHY_CFG
			|| a == `PLPC_ADDR_AN_ADV || a == `PLPC_ADDR_AN_RES;
	endfunction

	assign wr_en = psel_i & penable_i & pready_q & pwrite_i & addr_hit(paddr_i);

	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready_q <= 1'b0;
			prdata_o <= 32'h00000000;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_q <= psel_i & penable_i & !pready_q;
			pslverr_o <= psel_i & penable_i & !pready_q & !addr_hit(paddr_i);
			if (psel_i && penable_i && !pready_q)
			begin
				case (paddr_i)
					`PLPC_ADDR_BUS_MODE: prdata_o <= {31'h00000000, bus_mode_q};
					`PLPC_ADDR_PHY_CTRL: prdata_o <= {16'h0000, ctrl_q};
					`PLPC_ADDR_PHY_CFG: prdata_o <= {16'h0000, cfg_q};
					`PLPC_ADDR_AN_ADV: prdata_o <= {16'h0000, adv_q};
					`PLPC_ADDR_AN_RES: prdata_o <= {25'h0000000, paused_o, col_o, crs_o,
						res_pause_q, full, speed100, an_q == PLPC_AN_DONE};
					default: prdata_o <= 32'h00000000;
				endcase
			end
		end
	end
	assign pready_o = pready_q;

	// ====================================================================
	// Software resets
	// soft reset pulse
	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
			bus_mode_q <= 1'b0;
		else
			bus_mode_q <= wr_en && paddr_i == `PLPC_ADDR_BUS_MODE && pwdata_i[`PLPC_BM_SOFT_RST];
	end
	assign mac_rst = bus_mode_q;
	assign phy_rst = ctrl_q[`PLPC_CTRL_PHY_RST];

	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_q <= `PLPC_CTRL_RST;
			cfg_q <= `PLPC_CFG_RST;
			adv_q <= `PLPC_ADV_RST;
		end
		else if (phy_rst)
		begin
			ctrl_q <= `PLPC_CTRL_RST;
			cfg_q <= `PLPC_CFG_RST;
			adv_q <= `PLPC_ADV_RST;
		end
		else if (wr_en)
		begin
			if (paddr_i == `PLPC_ADDR_PHY_CTRL)
				ctrl_q <= pwdata_i[15:0];
			if (paddr_i == `PLPC_ADDR_PHY_CFG)
				cfg_q <= pwdata_i[15:0];
			if (paddr_i == `PLPC_ADDR_AN_ADV)
				adv_q <= pwdata_i[15:0];
		end
	end

	// ====================================================================
	// Auto-negotiation
	function automatic logic [1:0] resolve(input logic [15:0] c);
		if (c[`PLPC_ADV_100FD])
			return 2'b11;
		else if (c[`PLPC_ADV_100HD])
			return 2'b10;
		else if (c[`PLPC_ADV_10FD])
			return 2'b01;
		else
			return 2'b00;
	endfunction

	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			an_q <= PLPC_AN_IDLE;
			{res_100_q, res_full_q, res_pause_q} <= 3'b000;
		end
		else if (phy_rst || !ctrl_q[`PLPC_CTRL_AN_EN])
			an_q <= PLPC_AN_IDLE;
		else
		begin
			case (an_q)
				PLPC_AN_IDLE: an_q <= PLPC_AN_SEND;
				PLPC_AN_SEND:
				begin
					if (lp_page_valid_i)
					begin
						an_q <= PLPC_AN_DONE;
						{res_100_q, res_full_q} <= resolve(adv_q & lp_ability_i);
						res_pause_q <= adv_q[`PLPC_ADV_PAUSE] & lp_ability_i[`PLPC_ADV_PAUSE];
					end
				end
				PLPC_AN_DONE: an_q <= PLPC_AN_DONE;
				default: an_q <= PLPC_AN_IDLE;
			endcase
		end
	end

	assign speed100 = ctrl_q[`PLPC_CTRL_AN_EN] ? res_100_q : ctrl_q[`PLPC_CTRL_SPEED100];
	assign full = ctrl_q[`PLPC_CTRL_AN_EN] ? res_full_q : ctrl_q[`PLPC_CTRL_FULL];
	assign int_lb = ctrl_q[`PLPC_CTRL_INT_LB];
	assign rmt_lb = cfg_q[`PLPC_CFG_RMT_LB] & speed100 & !int_lb;

	// ====================================================================
	// Serial paths, stepped on each link clock rising edge
	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_nrzi_q <= 1'b0;
			rx_prev_q <= 1'b0;
		end
		else if (bit_tick)
		begin
			tx_nrzi_q <= cfg_q[`PLPC_CFG_NRZI_EN] ? tx_nrzi_q ^ tx_nrz_bit_i : tx_nrz_bit_i;
			rx_prev_q <= rx_in;
		end
	end

	assign rx_in = (int_lb && speed100) ? tx_nrzi_q : rx_cdr_s;
	assign lnk.bit_tick = bit_tick;
	assign lnk.rx_nrz = cfg_q[`PLPC_CFG_NRZI_EN] ? !(rx_in ^ rx_prev_q) : rx_in;
	assign lnk.end_det = rx_esd_i | rx_idle_i | phy_rst;

	plpc_crs_det u_crs
	(
		.clk_i(clk_sys_i),
		.rst_b_i(rst_b),
		.lnk(lnk.crs)
	);

	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			line_tx_bit_o <= 1'b0;
			line_drv_en_o <= 1'b0;
			cdr10_in_o <= 1'b0;
			crs_o <= 1'b0;
			col_o <= 1'b0;
			flp_send_o <= 1'b0;
			advert_word_o <= 16'h0000;
		end
		else
		begin
			line_tx_bit_o <= rmt_lb ? rx_cdr_s : tx_nrzi_q;
			line_drv_en_o <= !int_lb;
			cdr10_in_o <= (int_lb && !speed100) ? tx_manch_i : l10_q[1];
			crs_o <= full ? lnk.crs_rx : (lnk.crs_rx | tx_active_i);
			col_o <= !full & tx_active_i & lnk.crs_rx;
			flp_send_o <= an_q == PLPC_AN_SEND;
			advert_word_o <= adv_q;
		end
	end

	// ====================================================================
	// Pause control
	// pause gated by result
	assign lnk.pause_en = !mac_rst & ctrl_q[`PLPC_CTRL_AN_EN] & (an_q == PLPC_AN_DONE)
		& res_full_q & res_pause_q;
	assign pause_frame = rx_frame_done_i && rx_type_i == `PLPC_MAC_CTL_TYPE
		&& rx_opcode_i == `PLPC_PAUSE_OPCODE
		&& (rx_da_i == `PLPC_PAUSE_MCAST || rx_da_i == station_addr_i);
	assign lnk.load = pause_frame;
	assign lnk.load_val = rx_param_i;

	// one tick per slot time
	// Restarted by each pause frame, so the first slot is never cut short
	assign slot_end = slot_cnt_q >= 11'(speed100 ? `PLPC_SLOT_CYC_100 - 1
		: `PLPC_SLOT_CYC_10 - 1);
	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
			slot_cnt_q <= 11'h000;
		else if (mac_rst || pause_frame || slot_end)
			slot_cnt_q <= 11'h000;
		else
			slot_cnt_q <= slot_cnt_q + 11'h001;
	end
	assign lnk.slot_tick = slot_end;

	plpc_pause_timer u_pause
	(
		.clk_i(clk_sys_i),
		.rst_b_i(rst_b),
		.lnk(lnk.pse)
	);

	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_start_ok_o <= 1'b0;
			paused_o <= 1'b0;
		end
		else
		begin
			tx_start_ok_o <= !lnk.paused & !pause_frame_nz(pause_frame, rx_param_i, lnk.pause_en);
			paused_o <= lnk.paused;
		end
	end

	function automatic logic pause_frame_nz(input logic f, input logic [15:0] v, input logic en);
		return f & en & (v != 16'h0000);
	endfunction

	// ====================================================================
	// LEDs; the blink divider is long, so it is a parameter for simulation
	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			led_cnt_q <= 20'h00000;
			blink20_q <= 1'b0;
			blink10_q <= 1'b0;
		end
		else if (mac_rst)
		begin
			led_cnt_q <= 20'h00000;
			blink20_q <= 1'b0;
			blink10_q <= 1'b0;
		end
		else if (led_cnt_q == 20'(LED_TICK_CYC - 1))
		begin
			led_cnt_q <= 20'h00000;
			blink20_q <= !blink20_q;
			if (blink20_q)
				blink10_q <= !blink10_q;
		end
		else
			led_cnt_q <= led_cnt_q + 20'h00001;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
			led_o <= 4'h0;
		else if (cfg_q[`PLPC_CFG_LED4])
		begin
			led_o[0] <= link_ok_i & speed100;
			led_o[1] <= link_ok_i & !speed100;
			led_o[2] <= (crs_o | tx_active_i) & blink10_q;
			led_o[3] <= col_o ? blink20_q : full;
		end
		else
		begin
			led_o[0] <= speed100;
			led_o[1] <= ((crs_o | tx_active_i) & !col_o) ? blink10_q : link_ok_i;
			led_o[2] <= col_o ? blink20_q : full;
			led_o[3] <= 1'b0;
		end
	end

	// ====================================================================
	// Checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b);

	a_crs_half_tx: assert property (!full && tx_active_i |=> crs_o)
		else $error("half duplex carrier missing during transmit");
	a_crs_full_rx: assert property (full && !lnk.crs_rx |=> !crs_o)
		else $error("full duplex carrier without reception");
	a_col_full_off: assert property (full |=> !col_o)
		else $error("collision shown in full duplex");
	a_iso_loop: assert property (int_lb |=> !line_drv_en_o)
		else $error("line driven during internal loop-back");
	a_rlb_path: assert property (rmt_lb |=> line_tx_bit_o == $past(rx_cdr_s))
		else $error("remote loop-back data not returned");
	a_an_start: assert property (an_q == PLPC_AN_IDLE && ctrl_q[`PLPC_CTRL_AN_EN] && !phy_rst |=> ##1 flp_send_o)
		else $error("negotiation did not start");
	a_tx_hold: assert property (lnk.paused |=> !tx_start_ok_o)
		else $error("new frame allowed while paused");
	a_srst_self: assert property (bus_mode_q |=> !bus_mode_q)
		else $error("soft reset bit stuck");
	a_phy_soft_reset_bit_self: assert property (phy_rst |=> !phy_rst && ctrl_q == `PLPC_CTRL_RST)
		else $error("transceiver reset did not restore defaults");

	c_an_done: cover property (an_q == PLPC_AN_SEND ##1 an_q == PLPC_AN_DONE);
	c_pause_load: cover property (lnk.pause_en && pause_frame && rx_param_i != 16'h0000);
	c_half_col: cover property (col_o);
endmodule
`default_nettype wire

// File: test/plpc_partner.sv
// Link partner model: serial line bits under a bit clock that runs only within frames
`timescale 1ns/1ps
`default_nettype none
module plpc_partner
(
	// Line side
	output logic bclk_o,
	output logic bit_o,
	// Negotiation page
	output logic [15:0] ability_o
);
	initial
	begin
		bclk_o = 1'b0;
		bit_o = 1'b1;
		ability_o = 16'h05E1;
	end
	// ====================================================================
	// Frame sender
	task automatic send(input logic [19:0] bits, input int n);
		// Line changes stay clear of the system clock edges
		#10;
		for (int i = n - 1; i >= 0; i--)
		begin
			bit_o = bits[i];
			#160 bclk_o = 1'b1;
			#160 bclk_o = 1'b0;
		end
		// A released line must not look like the last bit held
		bit_o = ~bit_o;
	endtask
endmodule
`default_nettype wire

// File: test/phy_link_pause_control_test.sv
// Self-checking bench for the link and pause control block
`timescale 1ns/1ps
`default_nettype none
`include "plpc_params.svh"
module phy_link_pause_control_test;
	import plpc_pkg::*;
	localparam int SLOT = `PLPC_SLOT_CYC_100;
	localparam logic [47:0] MC = `PLPC_PAUSE_MCAST;
	logic clk_sys_i, rst_b_i, psel, penable, pwrite, pready, pslverr, bclk, lbit;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic tx_nrz, tx_manch, tx_active, rx_esd, rx_idle, link_ok, lp_valid, fdone;
	logic [47:0] da, station;
	logic [15:0] ftype, fop, fparam;
	logic line_bit, drv_en, cdr10, crs, col, flp, tx_ok, paused;
	plpc_word_t lp_ability, advert;
	logic [3:0] led;
	logic [32:0] q[$];
	int bad_count, n_compared, t, i;
	plpc_partner u_peer (.bclk_o(bclk), .bit_o(lbit), .ability_o(lp_ability));
	plpc_top #(.LED_TICK_CYC(4)) u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.rx_bclk_i(bclk), .rx_cdr_bit_i(lbit), .rx_line10_i(lbit), .tx_nrz_bit_i(tx_nrz),
		.tx_manch_i(tx_manch), .tx_active_i(tx_active), .rx_esd_i(rx_esd),
		.rx_idle_i(rx_idle), .link_ok_i(link_ok), .lp_ability_i(lp_ability),
		.lp_page_valid_i(lp_valid), .rx_frame_done_i(fdone), .rx_da_i(da),
		.rx_type_i(ftype), .rx_opcode_i(fop), .rx_param_i(fparam),
		.station_addr_i(station), .line_tx_bit_o(line_bit), .line_drv_en_o(drv_en),
		.cdr10_in_o(cdr10), .crs_o(crs), .col_o(col), .flp_send_o(flp),
		.advert_word_o(advert), .tx_start_ok_o(tx_ok), .paused_o(paused), .led_o(led));
	initial
	begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	// ====================================================================
	// Checks and report
	task automatic test_done();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Read answers are matched against the oldest note in the queue
	always @(posedge clk_sys_i)
		if (pready === 1'b1 && psel && penable && !pwrite)
			cmp({pslverr, prdata}, (q.size() > 0) ? q.pop_front() : 33'h1FFFFFFFF);
	// ====================================================================
	// Bus and frame drivers
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		for (k = 0; k < 20 && pready !== 1'b1; k++)
			@(posedge clk_sys_i);
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20)
		begin
			bad_count++;
			test_done();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
		q.push_back({err, e});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic pframe(input logic [47:0] d, input logic [15:0] op, input logic [15:0] tm);
		@(posedge clk_sys_i);
		da <= d;
		ftype <= `PLPC_MAC_CTL_TYPE;
		fop <= op;
		fparam <= tm;
		fdone <= 1'b1;
		@(posedge clk_sys_i);
		fdone <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic pulse_end(input logic esd);
		@(posedge clk_sys_i);
		rx_esd <= esd;
		rx_idle <= ~esd;
		@(posedge clk_sys_i);
		rx_esd <= 1'b0;
		rx_idle <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
	endtask
	always @(posedge clk_sys_i)
		tx_nrz <= 1'($urandom);
	// ====================================================================
	// Main sequence
	initial
	begin
		{rst_b_i, psel, penable, pwrite, tx_manch, tx_active, rx_esd, rx_idle} = 8'h00;
		{lp_valid, fdone, paddr, pwdata, da, ftype, fop, fparam} = '0;
		link_ok = 1'b1;
		tx_nrz = 1'b0;
		t = $urandom(52);
		station = {16'($urandom), 32'($urandom)};
		t = 1 + $urandom % 3;
		repeat (12) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		cmp(flp, 1'b1);
		cmp(advert, 16'h05E1);
		rd(`PLPC_ADDR_PHY_CFG, 32'h0080, 1'b0);
		rd(8'h20, 32'h0, 1'b1);
		pframe(MC, `PLPC_PAUSE_OPCODE, 16'h0005);
		cmp(paused, 1'b0);
		@(posedge clk_sys_i);
		lp_valid <= 1'b1;
		@(posedge clk_sys_i);
		lp_valid <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		rd(`PLPC_ADDR_AN_RES, 32'h000F, 1'b0);
		cmp({led[3], led[0]}, 2'b01);
		pframe(MC, 16'h0002, 16'h0005);
		cmp(paused, 1'b0);
		pframe(station, `PLPC_PAUSE_OPCODE, 16'(t));
		cmp({paused, tx_ok}, 2'b10);
		for (i = 0; i < (t + 1) * SLOT && paused !== 1'b0; i++)
			@(posedge clk_sys_i);
		cmp({paused, i >= t * SLOT - 2 && i <= t * SLOT}, 2'b01);
		repeat (3) @(posedge clk_sys_i);
		cmp(tx_ok, 1'b1);
		pframe(MC, `PLPC_PAUSE_OPCODE, 16'hFFFF);
		pframe(MC, `PLPC_PAUSE_OPCODE, 16'h0000);
		cmp(paused, 1'b0);
		pframe(MC, `PLPC_PAUSE_OPCODE, 16'hFFFF);
		apb(1'b1, `PLPC_ADDR_BUS_MODE, 32'h1);
		rd(`PLPC_ADDR_BUS_MODE, 32'h0, 1'b0);
		cmp(paused, 1'b0);
		apb(1'b1, `PLPC_ADDR_PHY_CFG, 32'h0);
		apb(1'b1, `PLPC_ADDR_PHY_CTRL, 32'h8000);
		rd(`PLPC_ADDR_PHY_CTRL, 32'h3100, 1'b0);
		rd(`PLPC_ADDR_PHY_CFG, 32'h0080, 1'b0);
		apb(1'b1, `PLPC_ADDR_PHY_CFG, 32'h0);
		apb(1'b1, `PLPC_ADDR_PHY_CTRL, 32'h2000);
		u_peer.send(20'h003FF, 10);
		pulse_end(1'b0);
		u_peer.send(20'h000FF, 10);
		repeat (12) @(posedge clk_sys_i);
		cmp(crs, 1'b0);
		u_peer.send(20'h0017F, 10);
		repeat (12) @(posedge clk_sys_i);
		cmp(crs, 1'b1);
		tx_active <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		cmp(col, 1'b1);
		tx_active <= 1'b0;
		pulse_end(1'b1);
		cmp(crs, 1'b0);
		tx_active <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		cmp({crs, col}, 2'b10);
		apb(1'b1, `PLPC_ADDR_PHY_CTRL, 32'h2100);
		repeat (4) @(posedge clk_sys_i);
		cmp({crs, col}, 2'b00);
		u_peer.send(20'h0017F, 10);
		repeat (12) @(posedge clk_sys_i);
		cmp({crs, col}, 2'b10);
		tx_active <= 1'b0;
		apb(1'b1, `PLPC_ADDR_PHY_CFG, 32'h0201);
		for (int b = 0; b < 2; b++)
		begin
			u_peer.send({19'h00000, ~b[0]}, 1);
			repeat (6) @(posedge clk_sys_i);
			cmp(line_bit, b[0]);
		end
		cmp({led[3], led[1], led[0]}, 3'b101);
		apb(1'b1, `PLPC_ADDR_PHY_CTRL, 32'h4000);
		for (int v = 0; v < 2; v++)
		begin
			tx_manch <= v[0];
			repeat (4) @(posedge clk_sys_i);
			cmp(cdr10, v[0]);
		end
		cmp({drv_en, led[0]}, 2'b00);
		test_done();
	end
endmodule
`default_nettype wire
